// ### common/sbtc_pkg.sv
package sbtc_pkg;
    localparam int          SBTC_NM        = 3;
    localparam int          SBTC_AW        = 32;
    localparam int          SBTC_DW        = 64;
    localparam int          SBTC_BA_W      = 14;
    localparam logic [11:0] SBTC_CRM_ADDR  = 12'hc0f;
    localparam logic [31:0] SBTC_BASE_RST  = 32'h8000_0000;
    localparam logic [31:0] SBTC_CFG_RST   = 32'h0000_0001;
    localparam int          SBTC_CFG_PIPE  = 0;
    localparam int          SBTC_CFG_PM_LO = 1;
    localparam int          SBTC_CFG_SP_LO = 3;
    localparam logic [1:0]  SBTC_BEATS_BURST = 2'h3;
    typedef enum logic [1:0] {
        SBTC_PARK_NONE = 2'b00,
        SBTC_PARK_LAST = 2'b01,
        SBTC_PARK_PROG = 2'b10
    } sbtc_park_t;
    typedef enum logic [1:0] {
        SBTC_RT_PERIPH = 2'b00,
        SBTC_RT_SLAVE  = 2'b01,
        SBTC_RT_EXTERN = 2'b10
    } sbtc_route_t;
endpackage

// ### rtl/sbtc_top.sv
module sbtc_top
    import sbtc_pkg::*;
(
    input  wire logic                       core_clk,
    input  wire logic                       rst,
    input  wire logic                       crm_wr,
    input  wire logic [11:0]                crm_addr,
    input  wire logic [31:0]                crm_wdata,
    input  wire logic                       dbg_wr,
    input  wire logic [31:0]                dbg_wdata,
    output logic      [31:0]                dbg_rdata,
    input  wire logic [31:0]                arb_cfg_wdata,
    input  wire logic                       arb_cfg_wr,
    input  wire logic [SBTC_NM*3-1:0]       prio,
    input  wire logic [SBTC_NM-1:0]         abus_req,
    output logic      [SBTC_NM-1:0]         abus_gnt,
    input  wire logic                       ats,
    input  wire logic [SBTC_AW-1:0]         addr,
    input  wire logic                       burst,
    input  wire logic                       slave_hit,
    input  wire logic                       slave_aack,
    input  wire logic                       retry,
    output logic                            aack,
    output logic      [1:0]                 route,
    output logic      [SBTC_NM-1:0]         dbus_gnt,
    input  wire logic                       ta,
    output logic                            periph_sel,
    output logic                            ext_sel,
    output logic      [1:0]                 outstanding
);
    logic [31:0]            base_q, base_d, cfg_q, cfg_d;
    logic [SBTC_NM-1:0]     agnt_q, agnt_d, dgnt_q, dgnt_d, last_q, last_d;
    logic [SBTC_NM*2-1:0]   fifo_q, fifo_d;
    logic [SBTC_NM*2-1:0]   lru_q, lru_d;
    logic [1:0]             cnt_q, cnt_d, beat_q, beat_d, rt_q, rt_d;
    logic                   aack_q, aack_d, ps_q, ps_d, es_q, es_d;
    logic                   bst_q[2];
    logic                   bst_d[2];

    function automatic logic win_hit(input logic [31:0] a, input logic [31:0] b);
        return a[SBTC_AW-1 -: SBTC_BA_W] == b[SBTC_AW-1 -: SBTC_BA_W];
    endfunction

    logic        pipe_on, can_grant, dtn_done, a_done, hit;
    sbtc_park_t  park;
    logic [1:0]  sp;
    int          best, bp, i;

    always_comb
    begin
        base_d  = base_q;
        cfg_d   = cfg_q;
        if (crm_wr && crm_addr == SBTC_CRM_ADDR)
            base_d = {crm_wdata[31:18], 18'h0};
        if (dbg_wr)
            base_d = {dbg_wdata[31:18], 18'h0};
        if (arb_cfg_wr)
            cfg_d = arb_cfg_wdata;
        pipe_on = cfg_q[SBTC_CFG_PIPE];
        park    = sbtc_park_t'(cfg_q[SBTC_CFG_PM_LO +: 2]);
        sp      = cfg_q[SBTC_CFG_SP_LO +: 2];
        hit     = win_hit(addr, base_q);
        a_done  = ats && !retry && (hit || slave_aack);
        dtn_done = (dgnt_q != '0) && ta && (!bst_q[0] || beat_q == SBTC_BEATS_BURST);
        // Outstanding count limits pipeline depth
        cnt_d = cnt_q + {1'b0, a_done} - {1'b0, dtn_done};
        can_grant = (agnt_q == '0) && !ats &&
                    (pipe_on ? (cnt_q < 2'd2) : (cnt_q == 2'd0));
        best = -1;
        bp   = -1;
        for (i = 0; i < SBTC_NM; i++)
            if (abus_req[i] && (int'(prio[i*3 +: 3]) > bp ||
                (int'(prio[i*3 +: 3]) == bp && best >= 0 && lru_q[i*2 +: 2] > lru_q[best*2 +: 2])))
            begin
                best = i;
                bp   = int'(prio[i*3 +: 3]);
            end
        // Grant stands until the master starts or is retried
        agnt_d = agnt_q;
        last_d = last_q;
        lru_d  = lru_q;
        if (ats || retry)
            agnt_d = '0;
        else if (can_grant)
        begin
            if (best >= 0)
            begin
                agnt_d       = '0;
                agnt_d[best] = 1'b1;
                last_d = agnt_d;
                for (i = 0; i < SBTC_NM; i++)
                    lru_d[i*2 +: 2] = (i == best) ? 2'd0 :
                        (lru_q[i*2 +: 2] == 2'd3 ? 2'd3 : lru_q[i*2 +: 2] + 2'd1);
            end
            else if (park == SBTC_PARK_LAST)
                agnt_d = last_q;
            else if (park == SBTC_PARK_PROG && int'(sp) < SBTC_NM)
                agnt_d[sp] = 1'b1;
        end
        // Order fifo of data owners, two slots
        fifo_d = fifo_q;
        bst_d  = bst_q;
        if (dtn_done)
        begin
            fifo_d = {{SBTC_NM{1'b0}}, fifo_q[SBTC_NM*2-1 -: SBTC_NM]};
            bst_d[0] = bst_q[1];
            bst_d[1] = 1'b0;
        end
        if (a_done)
        begin
            if (cnt_q - {1'b0, dtn_done} == 2'd0)
            begin
                fifo_d[SBTC_NM-1:0] = last_q;
                bst_d[0] = burst;
            end
            else
            begin
                fifo_d[SBTC_NM*2-1 -: SBTC_NM] = last_q;
                bst_d[1] = burst;
            end
        end
        dgnt_d  = fifo_d[SBTC_NM-1:0];
        beat_d  = dtn_done ? 2'd0 : ((dgnt_q != '0 && ta) ? beat_q + 2'd1 : beat_q);
        aack_d  = a_done;
        ps_d    = ats && hit;
        es_d    = ats && !hit && !slave_hit;
        rt_d    = !ats ? rt_q : hit ? SBTC_RT_PERIPH : slave_hit ? SBTC_RT_SLAVE : SBTC_RT_EXTERN;
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            base_q  <= SBTC_BASE_RST;
            cfg_q   <= SBTC_CFG_RST;
            agnt_q  <= '0;
            dgnt_q  <= '0;
            last_q  <= '0;
            fifo_q  <= '0;
            lru_q   <= '0;
            cnt_q   <= 2'd0;
            beat_q  <= 2'd0;
            rt_q    <= 2'd0;
            aack_q  <= 1'b0;
            ps_q    <= 1'b0;
            es_q    <= 1'b0;
            bst_q   <= '{1'b0, 1'b0};
        end
        else
        begin
            base_q  <= base_d;
            cfg_q   <= cfg_d;
            agnt_q  <= agnt_d;
            dgnt_q  <= dgnt_d;
            last_q  <= last_d;
            fifo_q  <= fifo_d;
            lru_q   <= lru_d;
            cnt_q   <= cnt_d;
            beat_q  <= beat_d;
            rt_q    <= rt_d;
            aack_q  <= aack_d;
            ps_q    <= ps_d;
            es_q    <= es_d;
            bst_q   <= bst_d;
        end
    end

    assign dbg_rdata   = base_q;
    assign abus_gnt    = agnt_q;
    assign dbus_gnt    = dgnt_q;
    assign aack        = aack_q;
    assign route       = rt_q;
    assign periph_sel  = ps_q;
    assign ext_sel     = es_q;
    assign outstanding = cnt_q;
endmodule

// ### tb/sbtc_top_sva.sv
module sbtc_top_sva(
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic        ats,
    input wire logic        retry,
    input wire logic        slave_hit,
    input wire logic        slave_aack,
    input wire logic        aack,
    input wire logic        periph_sel,
    input wire logic        ext_sel,
    input wire logic [31:0] addr,
    input wire logic [31:0] dbg_rdata,
    input wire logic [1:0]  route,
    input wire logic [1:0]  outstanding,
    input wire logic [2:0]  abus_gnt,
    input wire logic [2:0]  dbus_gnt
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    wire win = addr[31:18] == dbg_rdata[31:18];
    sequence s_take; ats && !retry; endsequence
    property p_win; s_take ##0 win |=> aack && periph_sel && !ext_sel && route == 2'h0; endproperty
    a_win: assert property (p_win) else $error("window access left chip");
    property p_slave; s_take ##0 !win && slave_hit && slave_aack |=> aack && route == 2'h1 && !ext_sel; endproperty
    a_slave: assert property (p_slave) else $error("slave route wrong");
    property p_ext; s_take ##0 !win && !slave_hit && slave_aack |=> route == 2'h2 && ext_sel && !periph_sel; endproperty
    a_ext: assert property (p_ext) else $error("external route wrong");
    property p_retry; ats && retry |=> !aack; endproperty
    a_retry: assert property (p_retry) else $error("retried address acknowledged");
    property p_rst; $past(rst) |-> dbg_rdata == 32'h8000_0000 && outstanding == 2'h0; endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
    property p_align; dbg_rdata[17:0] == 18'h0; endproperty
    a_align: assert property (p_align) else $error("base not aligned");
    property p_third; outstanding == 2'h2 && abus_gnt == 3'h0 |=> abus_gnt == 3'h0; endproperty
    a_third: assert property (p_third) else $error("third tenure granted");
    property p_dgnt; aack |-> dbus_gnt != 3'h0 ##1 dbus_gnt != 3'h0; endproperty
    a_dgnt: assert property (p_dgnt) else $error("no data owner after acknowledge");
    property p_one; $onehot0(abus_gnt) && $onehot0(dbus_gnt); endproperty
    a_one: assert property (p_one) else $error("grant not one-hot");
endmodule
bind sbtc_top sbtc_top_sva i_sva(.*);

// ### tb/sbtc_far_model.sv
module sbtc_far_model(
    input wire logic        core_clk,
    input wire logic [2:0]  abus_gnt,
    input wire logic [2:0]  dbus_gnt,
    output logic     [2:0]  abus_req,
    output logic            ats,
    output logic            burst,
    output logic            slave_hit,
    output logic            slave_aack,
    output logic            retry,
    output logic            ta,
    output logic     [31:0] addr
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {abus_req, ats, burst, slave_hit, slave_aack, retry, ta, addr} = '0;
    task automatic addr_ten(input int m, input logic [31:0] a, input logic b, h, k, r);
        abus_req[m] = 1'b1;
        for (int i = 0; i < 20 && !abus_gnt[m]; i++) @(negedge core_clk);
        {abus_req[m], ats, addr, burst, slave_hit, slave_aack, retry} = {2'b01, a, b, h, k, r};
        @(negedge core_clk);
        {ats, addr, slave_aack, retry} = {1'b0, ~a, 2'b00}; // Address inverted, ats, slave_aack and retry cleared; burst and slave_hit keep their values
    endtask
    task automatic data_ten(input int n, d);
        @(negedge core_clk);
        for (int i = 0; i < 20 && dbus_gnt == 3'h0; i++) @(negedge core_clk);
        repeat (n)
        begin
            repeat (d)
            begin
                ta = 1'b0;
                @(negedge core_clk);
            end
            ta = 1'b1;
            @(negedge core_clk);
        end
        ta = 1'b0;
    endtask
endmodule

// ### tb/split_bus_tenure_control_test.sv
module split_bus_tenure_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk = 0, rst = 1, crm_wr = 0, dbg_wr = 0, arb_cfg_wr = 0, b;
    logic [11:0] crm_addr = 0;
    logic [31:0] crm_wdata = 0, dbg_wdata = 0, arb_cfg_wdata = 0, dbg_rdata, addr, base, v, a;
    logic [8:0]  prio = 0;
    logic [2:0]  abus_req, abus_gnt, dbus_gnt;
    logic        ats, burst, slave_hit, slave_aack, retry, aack, ta, periph_sel, ext_sel;
    logic [1:0]  route, outstanding;
    int          err_count = 0, checked = 0, k;
    initial forever #5 core_clk = ~core_clk;
    sbtc_top i_dut(.*);
    sbtc_far_model i_far(.*);
    task automatic chk(input string n, input logic [31:0] e, g);
        checked++;
        if (g !== e)
        begin
            err_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    function automatic logic [31:0] aligned(input logic [31:0] x);
        return {x[31:18], 18'h0};
    endfunction
    task automatic wr_base(input logic [11:0] ad, input logic [31:0] d, input logic dbg);
        {crm_wr, dbg_wr, crm_addr, crm_wdata, dbg_wdata} = {!dbg, dbg, ad, d, d};
        @(negedge core_clk);
        {crm_wr, dbg_wr} = 2'b00;
        @(negedge core_clk);
    endtask
    initial
    begin
        #20us;
        err_count++;
        tally_and_finish;
    end
    initial
    begin
        v = $urandom(32'h85cc);
        prio = 9'($urandom);
        repeat (6) @(negedge core_clk);
        rst = 0;
        chk("reset base", 32'h8000_0000, dbg_rdata);
        v = $urandom;
        base = aligned(v);
        wr_base(12'hc0f, v, 0);
        chk("move base", base, dbg_rdata);
        wr_base(12'hc0e, ~v, 0);
        chk("other move", base, dbg_rdata);
        v = $urandom;
        base = aligned(v);
        wr_base(12'h000, v, 1);
        chk("debug base", base, dbg_rdata);
        for (int i = 0; i < 9; i++)
        begin
            k = i % 3;
            b = 1'($urandom);
            a = {(k == 0) ? base[31:18] : ~base[31:18], 18'($urandom)};
            i_far.addr_ten(k, a, b, k == 1, k != 0, 0);
            chk("aack", 1, aack);
            chk("route", k, route);
            chk("sel", {k == 0, k == 2}, {periph_sel, ext_sel});
            chk("data owner", 32'h1 << k, dbus_gnt);
            i_far.data_ten(b ? 4 : 1, $urandom % 3);
            chk("data end", 0, {outstanding, dbus_gnt});
        end
        i_far.addr_ten(1, base | 32'h40, 0, 0, 0, 1);
        chk("retry", 0, {aack, outstanding});
        i_far.addr_ten(0, base, 0, 0, 0, 0);
        i_far.addr_ten(1, ~base, 0, 1, 1, 0);
        chk("two out", 2, outstanding);
        i_far.abus_req[2] = 1'b1;
        repeat (3) @(negedge core_clk);
        chk("third held", 0, abus_gnt);
        i_far.data_ten(1, 0);
        for (int i = 0; i < 4 && dbus_gnt !== 3'h2; i++) @(negedge core_clk);
        chk("data order", 2, dbus_gnt);
        i_far.addr_ten(2, base, 1, 0, 0, 0);
        chk("third", 2, outstanding);
        tally_and_finish;
    end
endmodule
